// ===== rtl/tdc_pkg.sv
// Constants, field layout and helpers of the transfer descriptor engine
//----------------------------------------------------------------------
// Behaviour
//----------------------------------------------------------------------
// Behaviour
// - Destination mode holds the destination address or steps it per transfer.
// - Area select one puts the repeat/block area on source, zero on destination.
// - Interrupt condition comes from the descriptor's interrupt select bit.
// - Chain condition select is ignored while chain enable is zero.
// - Before a chained transfer: no completion check, flag kept, no interrupt.
// - Chaining happens only with chain enable set, condition from select bit.
// - Source address is read from offset 0x04 and written back there.
// - Destination address is read from offset 0x08 and written back there.
// - Count word is a low byte 7:0 and a high byte 15:8.
// - Count word is read as the upper half of the word at offset 0x0C and written back at 0x0E.
// - Normal mode: 16-bit count down by one; 0x0000 means 65536.
// - Repeat mode: low byte counts down, 0x00 means 256, reloads from high.
// - Block mode: high byte is block size, low byte counts and reloads.
// - Mode 00/01 hold and skip write-back, 10 steps up, 11 steps down.
// - Select zero interrupts on completion in normal mode only, select one at the end of every activation that does not chain.
// - Condition zero chains always, one only when the counter ends or reloads.
// - Size 00 byte, 01 halfword, 10 word; step 1, 2 or 4.
package tdc_pkg;
  //--------------------------------------------------------------------
  // Descriptor layout
  //--------------------------------------------------------------------
  localparam logic [31:0] TDC_OFF_MODE = 32'h0000_0000;
  localparam logic [31:0] TDC_OFF_SRC = 32'h0000_0004;
  localparam logic [31:0] TDC_OFF_DST = 32'h0000_0008;
  localparam logic [31:0] TDC_OFF_CNTW = 32'h0000_000C;
  localparam logic [31:0] TDC_OFF_CNT = 32'h0000_000E;
  localparam logic [31:0] TDC_DESC_BYTES = 32'h0000_0010;
  // Mode word A sits in byte 3, mode word B in byte 2 of the first word
  localparam int TDC_MRA_LSB = 24;
  localparam int TDC_MRB_LSB = 16;
  localparam int TDC_CNT_LSB = 16;
  // Mode word A fields
  localparam int TDC_SM_LSB = 2;
  localparam int TDC_SZ_LSB = 4;
  localparam int TDC_MD_LSB = 6;
  // Mode word B fields
  localparam int TDC_DM_LSB = 2;
  localparam int TDC_AREA_BIT = 4;
  localparam int TDC_IRQSEL_BIT = 5;
  localparam int TDC_CHAIN_CONDITION_SELECT_BIT = 6;
  localparam int TDC_CHAIN_ENABLE_BIT = 7;
  //--------------------------------------------------------------------
  // Codes
  //--------------------------------------------------------------------
  localparam logic [1:0] TDC_MD_NORMAL = 2'h0;
  localparam logic [1:0] TDC_MD_REPEAT = 2'h1;
  localparam logic [1:0] TDC_MD_BLOCK = 2'h2;
  localparam logic [1:0] TDC_STEP_UP = 2'h2;
  localparam logic [1:0] TDC_STEP_DOWN = 2'h3;
  localparam logic [1:0] TDC_SZ_HALF = 2'h1;
  localparam logic [1:0] TDC_SZ_WORD = 2'h2;
  localparam logic [7:0] TDC_MODE_RST = 8'h00;
  localparam logic [31:0] TDC_ADDR_RST = 32'h0000_0000;
  localparam logic [15:0] TDC_CNT_RST = 16'h0000;

  // Address after one transfer; size picks step 1, 2 or 4
  function automatic logic [31:0] tdc_step(input logic [31:0] addr,
                                           input logic [1:0] mode,
                                           input logic [1:0] sz);
    logic [31:0] step;
    step = 32'h0000_0001 << sz;
    case (mode)
      TDC_STEP_UP: tdc_step = addr + step;
      TDC_STEP_DOWN: tdc_step = addr - step;
      default: tdc_step = addr;
    endcase
  endfunction : tdc_step
endpackage : tdc_pkg

// ===== rtl/tdc_cnt_if.sv
// Interface between the engine and its transfer counter
`timescale 1ns/1ps
interface tdc_cnt_if;
  logic [1:0] mode;
  logic [15:0] cnt;
  logic [15:0] cnt_nxt;
  logic reload;
  logic done;
  modport eng (output mode, output cnt, input cnt_nxt, input reload, input done);
  modport unit (input mode, input cnt, output cnt_nxt, output reload, output done);
endinterface : tdc_cnt_if

// ===== rtl/tdc_counter.sv
// Transfer counter step for normal, repeat and block modes
`timescale 1ns/1ps
module tdc_counter
  import tdc_pkg::*;
(
  tdc_cnt_if.unit cif
);
  wire [7:0] low = cif.cnt[7:0];
  wire [7:0] high = cif.cnt[15:8];
  wire normal = (cif.mode == TDC_MD_NORMAL);
  wire low_end = (low == 8'h01);
  wire [7:0] low_dec = low - 8'h01; // 0x00 wraps, so it counts 256

  assign cif.reload = !normal && low_end;
  assign cif.done = normal ? (cif.cnt == 16'h0001) : low_end;
  assign cif.cnt_nxt = normal ? (cif.cnt - 16'h0001) :
                       {high, (low_end ? high : low_dec)};
endmodule : tdc_counter

// ===== rtl/tdc_skid_buf.sv
// Small FIFO between the read and the write half of a transfer
`timescale 1ns/1ps
module tdc_skid_buf #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : bump

  assign o_in_ready = (cnt_r != FULL_CNT);
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data = mem_r[rp_r];

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= bump(wp_r);
      end
      if (pop) begin
        rp_r <= bump(rp_r);
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem_r[wp_r] <= i_in_data;
    end
  end
endmodule : tdc_skid_buf

// ===== rtl/tdc_engine.sv
// Descriptor-driven transfer engine: fetch, move, count, write back, chain
`timescale 1ns/1ps
module tdc_engine
  import tdc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_act_valid,
  output logic o_act_ready,
  input wire logic [31:0] i_act_desc_addr,
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [1:0] o_mem_size,
  output logic [31:0] o_mem_addr,
  output logic [31:0] o_mem_wdata,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_rdata,
  output logic o_irq,
  output logic o_flag_clear,
  output logic o_busy
);
  //--------------------------------------------------------------------
  // State
  //--------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_RD_MODE, ST_RD_SRC, ST_RD_DST, ST_RD_CNT, ST_XF_RD,
    ST_XF_WR, ST_WB_SRC, ST_WB_DST, ST_WB_CNT, ST_END
  } tdc_state_t;

  tdc_state_t state_r;
  tdc_state_t state_nxt;
  logic [31:0] desc_r;
  logic [7:0] mode_word_a_r;
  logic [7:0] mode_word_b_r;
  logic [31:0] src_r;
  logic [31:0] src_start_r;
  logic [31:0] dst_r;
  logic [31:0] dst_start_r;
  logic [15:0] cnt_r;
  logic done_r;
  logic irq_r;
  logic clr_r;

  //--------------------------------------------------------------------
  // Descriptor fields
  //--------------------------------------------------------------------
  wire [1:0] src_step_mode = mode_word_a_r[TDC_SM_LSB+:2];
  wire [1:0] transfer_size = mode_word_a_r[TDC_SZ_LSB+:2];
  wire [1:0] transfer_mode_select = mode_word_a_r[TDC_MD_LSB+:2];
  wire [1:0] dest_step_mode = mode_word_b_r[TDC_DM_LSB+:2];
  wire area_side_select = mode_word_b_r[TDC_AREA_BIT];
  wire irq_condition_select = mode_word_b_r[TDC_IRQSEL_BIT];
  wire chain_condition_select = mode_word_b_r[TDC_CHAIN_CONDITION_SELECT_BIT];
  wire chain_enable = mode_word_b_r[TDC_CHAIN_ENABLE_BIT];
  wire is_normal = (transfer_mode_select == TDC_MD_NORMAL);
  wire is_block = (transfer_mode_select == TDC_MD_BLOCK);
  wire src_wb = src_step_mode[1];
  wire dst_wb = dest_step_mode[1];

  //--------------------------------------------------------------------
  // Counter and data buffer
  //--------------------------------------------------------------------
  tdc_cnt_if cif ();
  assign cif.mode = transfer_mode_select;
  assign cif.cnt = cnt_r;

  tdc_counter u_counter (
    .cif (cif.unit)
  );

  logic buf_in_ready;
  logic buf_out_valid;
  logic [31:0] buf_out_data;
  wire xf_rd_fire = (state_r == ST_XF_RD) && i_mem_ack;
  wire xf_fire = (state_r == ST_XF_WR) && i_mem_ack;

  // A stalled write side leaves the read word parked here, never dropped
  tdc_skid_buf #(
    .WIDTH (32),
    .DEPTH (2)
  ) u_buf (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_in_valid (xf_rd_fire),
    .o_in_ready (buf_in_ready),
    .i_in_data (i_mem_rdata),
    .o_out_valid (buf_out_valid),
    .i_out_ready (xf_fire),
    .o_out_data (buf_out_data)
  );

  //--------------------------------------------------------------------
  // Per-transfer updates
  //--------------------------------------------------------------------
  wire area_reload = cif.reload;
  wire src_area_hit = area_reload && area_side_select;
  wire dst_area_hit = area_reload && !area_side_select;
  wire [31:0] src_nxt = src_area_hit ? src_start_r :
                        tdc_step(src_r, src_step_mode, transfer_size);
  wire [31:0] dst_nxt = dst_area_hit ? dst_start_r :
                        tdc_step(dst_r, dest_step_mode, transfer_size);
  // Chain select only counts while chain enable is set
  wire chain_take = chain_enable && (!chain_condition_select || done_r);
  // Completion counts for the interrupt only in normal mode
  wire irq_cond = irq_condition_select || (is_normal && done_r);
  tdc_state_t wb_first;
  assign wb_first = src_wb ? ST_WB_SRC : (dst_wb ? ST_WB_DST : ST_WB_CNT);

  //--------------------------------------------------------------------
  // Next state
  //--------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (i_act_valid) state_nxt = ST_RD_MODE;
      ST_RD_MODE: if (i_mem_ack) state_nxt = ST_RD_SRC;
      ST_RD_SRC: if (i_mem_ack) state_nxt = ST_RD_DST;
      ST_RD_DST: if (i_mem_ack) state_nxt = ST_RD_CNT;
      ST_RD_CNT: if (i_mem_ack) state_nxt = ST_XF_RD;
      ST_XF_RD: if (i_mem_ack) state_nxt = ST_XF_WR;
      ST_XF_WR: begin
        if (i_mem_ack) begin
          // Block mode moves a whole block per activation
          state_nxt = (is_block && !area_reload) ? ST_XF_RD : wb_first;
        end
      end
      ST_WB_SRC: if (i_mem_ack) state_nxt = dst_wb ? ST_WB_DST : ST_WB_CNT;
      ST_WB_DST: if (i_mem_ack) state_nxt = ST_WB_CNT;
      ST_WB_CNT: if (i_mem_ack) state_nxt = ST_END;
      ST_END: state_nxt = chain_take ? ST_RD_MODE : ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  //--------------------------------------------------------------------
  // Memory request decode
  //--------------------------------------------------------------------
  wire st_rd = (state_r == ST_RD_MODE) || (state_r == ST_RD_SRC) ||
               (state_r == ST_RD_DST) || (state_r == ST_RD_CNT);
  wire st_wb = (state_r == ST_WB_SRC) || (state_r == ST_WB_DST) ||
               (state_r == ST_WB_CNT);
  wire xf_rd_req = (state_r == ST_XF_RD) && buf_in_ready;
  wire xf_wr_req = (state_r == ST_XF_WR) && buf_out_valid;
  wire [31:0] desc_off =
    (state_r == ST_RD_SRC || state_r == ST_WB_SRC) ? TDC_OFF_SRC :
    (state_r == ST_RD_DST || state_r == ST_WB_DST) ? TDC_OFF_DST :
    (state_r == ST_RD_CNT) ? TDC_OFF_CNTW :
    (state_r == ST_WB_CNT) ? TDC_OFF_CNT : TDC_OFF_MODE;

  assign o_mem_req = st_rd || st_wb || xf_rd_req || xf_wr_req;
  assign o_mem_we = st_wb || (state_r == ST_XF_WR);
  assign o_mem_addr = (state_r == ST_XF_RD) ? src_r :
                      (state_r == ST_XF_WR) ? dst_r : desc_r + desc_off;
  assign o_mem_size = (state_r == ST_XF_RD || state_r == ST_XF_WR) ? transfer_size :
                      (state_r == ST_WB_CNT) ? TDC_SZ_HALF : TDC_SZ_WORD;
  assign o_mem_wdata = (state_r == ST_XF_WR) ? buf_out_data :
                       (state_r == ST_WB_SRC) ? src_r :
                       (state_r == ST_WB_DST) ? dst_r :
                       {16'h0000, cnt_r};
  assign o_act_ready = (state_r == ST_IDLE);
  assign o_busy = (state_r != ST_IDLE);
  assign o_irq = irq_r;
  assign o_flag_clear = clr_r;

  //--------------------------------------------------------------------
  // Registers
  //--------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_r <= ST_IDLE;
      desc_r <= TDC_ADDR_RST;
    end else begin
      state_r <= state_nxt;
      if ((state_r == ST_IDLE) && i_act_valid) begin
        desc_r <= i_act_desc_addr;
      end else if ((state_r == ST_END) && chain_take) begin
        desc_r <= desc_r + TDC_DESC_BYTES;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      mode_word_a_r <= TDC_MODE_RST;
      mode_word_b_r <= TDC_MODE_RST;
    end else if ((state_r == ST_RD_MODE) && i_mem_ack) begin
      mode_word_a_r <= i_mem_rdata[TDC_MRA_LSB+:8];
      mode_word_b_r <= i_mem_rdata[TDC_MRB_LSB+:8];
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      src_r <= TDC_ADDR_RST;
      src_start_r <= TDC_ADDR_RST;
      dst_r <= TDC_ADDR_RST;
      dst_start_r <= TDC_ADDR_RST;
    end else if ((state_r == ST_RD_SRC) && i_mem_ack) begin
      src_r <= i_mem_rdata;
      src_start_r <= i_mem_rdata;
    end else if ((state_r == ST_RD_DST) && i_mem_ack) begin
      dst_r <= i_mem_rdata;
      dst_start_r <= i_mem_rdata;
    end else if (xf_fire) begin
      src_r <= src_nxt;
      dst_r <= dst_nxt;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      cnt_r <= TDC_CNT_RST;
      done_r <= 1'b0;
    end else if ((state_r == ST_RD_CNT) && i_mem_ack) begin
      cnt_r <= i_mem_rdata[TDC_CNT_LSB+:16];
      done_r <= 1'b0;
    end else if (xf_fire) begin
      cnt_r <= cif.cnt_nxt;
      done_r <= done_r || cif.done;
    end
  end

  // Chained step keeps the source flag and stays silent
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      irq_r <= 1'b0;
      clr_r <= 1'b0;
    end else begin
      irq_r <= (state_r == ST_END) && !chain_take && irq_cond;
      clr_r <= (state_r == ST_END) && !chain_take && !irq_cond;
    end
  end

  //--------------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  property p_norm_dec;
    xf_fire && is_normal |=> cnt_r == $past(cnt_r) - 16'h0001;
  endproperty
  a_norm_dec: assert property (p_norm_dec) else $error("normal count not decremented");

  property p_rep_reload;
    xf_fire && (transfer_mode_select == TDC_MD_REPEAT) && cnt_r[7:0] == 8'h01
      |=> cnt_r[7:0] == cnt_r[15:8];
  endproperty
  a_rep_reload: assert property (p_rep_reload) else $error("repeat low byte not reloaded");

  property p_blk_loop;
    xf_fire && is_block && cnt_r[7:0] != 8'h01 |=> state_r == ST_XF_RD;
  endproperty
  a_blk_loop: assert property (p_blk_loop) else $error("block stopped early");

  property p_dst_fix;
    xf_fire && !dest_step_mode[1] && !dst_area_hit |=> dst_r == $past(dst_r);
  endproperty
  a_dst_fix: assert property (p_dst_fix) else $error("fixed destination moved");

  property p_dst_up;
    xf_fire && is_normal && dest_step_mode == TDC_STEP_UP
      |=> dst_r == $past(dst_r) + (32'h0000_0001 << $past(transfer_size));
  endproperty
  a_dst_up: assert property (p_dst_up) else $error("destination step wrong");

  property p_area_src;
    xf_fire && !is_normal && area_side_select && cnt_r[7:0] == 8'h01
      |=> src_r == src_start_r;
  endproperty
  a_area_src: assert property (p_area_src) else $error("source area not restored");

  property p_irq_each;
    state_r == ST_END && irq_condition_select && !chain_take |=> o_irq && !o_flag_clear;
  endproperty
  a_irq_each: assert property (p_irq_each) else $error("per-transfer irq missing");

  property p_chain_quiet;
    state_r == ST_END && chain_take
      |=> !o_irq && !o_flag_clear && state_r == ST_RD_MODE ##1 o_mem_req;
  endproperty
  a_chain_quiet: assert property (p_chain_quiet) else $error("chain step not quiet");

  property p_chain_off;
    state_r == ST_END && !chain_enable |=> state_r == ST_IDLE && (o_irq || o_flag_clear);
  endproperty
  a_chain_off: assert property (p_chain_off) else $error("chain while disabled");

  property p_norm_irq;
    state_r == ST_END && is_normal && done_r && !chain_take |=> o_irq;
  endproperty
  a_norm_irq: assert property (p_norm_irq) else $error("completion irq missing");

  property p_wb_src;
    state_r == ST_WB_SRC |-> o_mem_we && o_mem_addr == desc_r + TDC_OFF_SRC && o_mem_wdata == src_r;
  endproperty
  a_wb_src: assert property (p_wb_src) else $error("source write-back wrong");

  property p_wb_dst;
    state_r == ST_WB_DST |-> o_mem_we && o_mem_addr == desc_r + TDC_OFF_DST && o_mem_wdata == dst_r;
  endproperty
  a_wb_dst: assert property (p_wb_dst) else $error("destination write-back wrong");

  property p_wb_cnt;
    state_r == ST_WB_CNT |-> o_mem_req && o_mem_we && o_mem_addr == desc_r + TDC_OFF_CNT &&
      o_mem_size == TDC_SZ_HALF && o_mem_wdata[15:0] == cnt_r;
  endproperty
  a_wb_cnt: assert property (p_wb_cnt) else $error("count write-back wrong");

  property p_rd_cnt;
    state_r == ST_RD_CNT |-> !o_mem_we && o_mem_addr == desc_r + TDC_OFF_CNTW;
  endproperty
  a_rd_cnt: assert property (p_rd_cnt) else $error("count fetch address wrong");

  property p_xf_rd;
    state_r == ST_XF_RD && o_mem_req |-> !o_mem_we && o_mem_addr == src_r && o_mem_size == transfer_size;
  endproperty
  a_xf_rd: assert property (p_xf_rd) else $error("transfer read wrong");

  property p_xf_wr;
    state_r == ST_XF_WR && o_mem_req |-> o_mem_we && o_mem_addr == dst_r && o_mem_size == transfer_size;
  endproperty
  a_xf_wr: assert property (p_xf_wr) else $error("transfer write wrong");

  property p_dst_down;
    xf_fire && is_normal && dest_step_mode == TDC_STEP_DOWN
      |=> dst_r == $past(dst_r) - (32'h0000_0001 << $past(transfer_size));
  endproperty
  a_dst_down: assert property (p_dst_down) else $error("destination down step wrong");

  property p_area_dst;
    xf_fire && !is_normal && !area_side_select && cnt_r[7:0] == 8'h01
      |=> dst_r == dst_start_r;
  endproperty
  a_area_dst: assert property (p_area_dst) else $error("destination area not restored");

  property p_hi_keep;
    xf_fire && !is_normal |=> cnt_r[15:8] == 8'($past(cnt_r) >> 8);
  endproperty
  a_hi_keep: assert property (p_hi_keep) else $error("upper count byte changed");

  c_norm_done: cover property (state_r == ST_END && is_normal && done_r);
  c_chain: cover property (state_r == ST_END && chain_take);
  c_blk_reload: cover property (xf_fire && is_block && area_reload);
  c_buf_stall: cover property (state_r == ST_XF_RD && !buf_in_ready);
  c_rep_reload: cover property (xf_fire && transfer_mode_select == TDC_MD_REPEAT && area_reload);
endmodule : tdc_engine

// ===== verif/tdc_mem_model.sv
// Behavioural system-bus memory with adjustable answer delay
`timescale 1ns/1ps
module tdc_mem_model (
  input wire logic i_clock,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [1:0] i_size,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  output logic o_ack,
  output logic [31:0] o_rdata
);
  //--------------------------------------------------------------------
  // Storage and answer
  //--------------------------------------------------------------------
  logic [7:0] mem [0:4095];
  int delay = 0;
  int wait_cnt = 0;
  initial begin
    o_ack = 1'b0;
    o_rdata = 32'h0000_0000;
  end
  // Idle data toggles so a stale word never looks valid
  always @(posedge i_clock) begin
    if (o_ack || !i_req) begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
      wait_cnt <= 0;
    end else if (wait_cnt < delay) begin
      wait_cnt <= wait_cnt + 1;
    end else begin
      o_ack <= 1'b1;
      for (int b = 0; b < 4; b++) begin
        if (i_we && b < (1 << i_size)) mem[i_addr[11:0] + b] <= i_wdata[8*b +: 8];
        o_rdata[8*b +: 8] <= mem[i_addr[11:0] + b];
      end
    end
  end
endmodule : tdc_mem_model

// ===== verif/transfer_descriptor_counters_tb.sv
// Self-checking bench of the descriptor transfer engine
`timescale 1ns/1ps
module transfer_descriptor_counters_tb;
  import tdc_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic act_valid = 1'b0;
  logic [31:0] act_addr = 32'h0000_0000;
  logic act_ready, mem_req, mem_we, mem_ack, irq, flag_clear, busy;
  logic [1:0] mem_size;
  logic [31:0] mem_addr, mem_wdata, mem_rdata;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int irq_cnt = 0;
  int flag_cnt = 0;
  int irq0, flag0;
  always #12.5 i_clock = ~i_clock;
  tdc_engine i_tdc_engine (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_act_valid(act_valid),
    .o_act_ready(act_ready), .i_act_desc_addr(act_addr), .o_mem_req(mem_req),
    .o_mem_we(mem_we), .o_mem_size(mem_size), .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata),
    .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata), .o_irq(irq), .o_flag_clear(flag_clear),
    .o_busy(busy));
  tdc_mem_model i_tdc_mem_model (.i_clock(i_clock), .i_req(mem_req), .i_we(mem_we),
    .i_size(mem_size), .i_addr(mem_addr), .i_wdata(mem_wdata), .o_ack(mem_ack),
    .o_rdata(mem_rdata));
  //--------------------------------------------------------------------
  // Helpers
  //--------------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (flag_clear === 1'b1) flag_cnt <= flag_cnt + 1;
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end
  function automatic logic [7:0] pat(input int a);
    return 8'(a) ^ 8'h5A;
  endfunction : pat
  function automatic logic [31:0] rd32(input int a);
    return {i_tdc_mem_model.mem[a+3], i_tdc_mem_model.mem[a+2],
            i_tdc_mem_model.mem[a+1], i_tdc_mem_model.mem[a]};
  endfunction : rd32
  task automatic wr32(input int a, input logic [31:0] v);
    for (int b = 0; b < 4; b++) i_tdc_mem_model.mem[a+b] = v[8*b +: 8];
  endtask : wr32
  task automatic put_desc(input int a, input logic [7:0] ma, input logic [7:0] mb,
                          input logic [31:0] s, input logic [31:0] d, input logic [15:0] c);
    wr32(a, {ma, mb, 16'h0000});
    wr32(a + 4, s);
    wr32(a + 8, d);
    wr32(a + 12, {c, 16'h0000});
  endtask : put_desc
  // Request held from a falling edge until the falling edge after the rising edge that takes it
  task automatic activate(input logic [31:0] a);
    irq0 = irq_cnt;
    flag0 = flag_cnt;
    @(negedge i_clock);
    act_valid = 1'b1;
    act_addr = a;
    do @(posedge i_clock); while (act_ready !== 1'b1);
    @(negedge i_clock);
    act_valid = 1'b0;
    for (int n = 0; n < 3000 && busy !== 1'b0; n++) @(negedge i_clock);
    repeat (3) @(negedge i_clock);
  endtask : activate
  //--------------------------------------------------------------------
  // Table of plain cases
  //--------------------------------------------------------------------
  typedef struct {
    logic [7:0] ma, mb;
    logic [31:0] src, dst;
    logic [15:0] cnt;
    logic [31:0] e_src, e_dst;
    logic [15:0] e_cnt;
    logic e_irq;
  } tdc_row_t;
  tdc_row_t rows [6] = '{
    '{8'h28, 8'h08, 32'h100, 32'h200, 16'h0003, 32'h104, 32'h204, 16'h0002, 1'b0},
    '{8'h0C, 8'h0C, 32'h101, 32'h203, 16'h0001, 32'h100, 32'h202, 16'h0000, 1'b1},
    '{8'h10, 8'h24, 32'h140, 32'h240, 16'h0000, 32'h140, 32'h240, 16'hFFFF, 1'b1},
    '{8'h48, 8'h10, 32'h120, 32'h220, 16'h0101, 32'h120, 32'h220, 16'h0101, 1'b0},
    '{8'h54, 8'h08, 32'h160, 32'h300, 16'h0202, 32'h160, 32'h302, 16'h0201, 1'b0},
    '{8'hA8, 8'h08, 32'h400, 32'h500, 16'h0202, 32'h408, 32'h500, 16'h0202, 1'b0}};
  initial begin
    for (int i = 0; i < 4096; i++) i_tdc_mem_model.mem[i] = pat(i);
    repeat (20) @(negedge i_clock);
    check("ready in reset", {31'h0, act_ready}, 32'h1);
    check("busy in reset", {31'h0, busy}, 32'h0);
    check("req in reset", {31'h0, mem_req}, 32'h0);
    i_rst_n = 1'b1;
    $display("test reset done");
    // Aligned addresses in halfword/word rows and equal count bytes in repeat/block rows
    foreach (rows[r]) begin
      put_desc(0, rows[r].ma, rows[r].mb, rows[r].src, rows[r].dst, rows[r].cnt);
      activate(32'h0000_0000);
      check("src back", rd32(4), rows[r].e_src);
      check("dst back", rd32(8), rows[r].e_dst);
      check("count back", rd32(12) >> 16, {16'h0, rows[r].e_cnt});
      check("data", rd32(rows[r].dst) & 32'h0000_00FF, {24'h0, pat(rows[r].src)});
      check("irq", irq_cnt - irq0, {31'h0, rows[r].e_irq});
      check("flag", flag_cnt - flag0, {31'h0, !rows[r].e_irq});
      $display("test row %0d done", r);
    end
    // Chain always, slow memory
    i_tdc_mem_model.delay = 3;
    put_desc(0, 8'h28, 8'h88, 32'h600, 32'h700, 16'h0005);
    put_desc(16, 8'h08, 8'h08, 32'h610, 32'h710, 16'h0001);
    activate(32'h0000_0000);
    check("chain cnt0", rd32(12) >> 16, 32'h0004);
    check("chain cnt1", rd32(28) >> 16, 32'h0000);
    check("chain irq", irq_cnt - irq0, 32'h1);
    check("chain flag", flag_cnt - flag0, 32'h0);
    $display("test chain done");
    // Chain only at end: count not ending, no chain
    put_desc(0, 8'h28, 8'hC8, 32'h600, 32'h700, 16'h0005);
    put_desc(16, 8'h08, 8'h08, 32'h610, 32'h710, 16'h0001);
    activate(32'h0000_0000);
    check("cond cnt1", rd32(28) >> 16, 32'h0001);
    check("cond flag", flag_cnt - flag0, 32'h1);
    // Chain disabled: condition bit ignored
    put_desc(0, 8'h28, 8'h48, 32'h600, 32'h700, 16'h0001);
    activate(32'h0000_0000);
    check("off cnt1", rd32(28) >> 16, 32'h0001);
    check("off irq", irq_cnt - irq0, 32'h1);
    $display("test chain condition done");
    // Reset in mid-fetch drops the activation; a fresh one then runs clean
    put_desc(0, 8'h28, 8'h08, 32'h100, 32'h200, 16'h0003);
    @(negedge i_clock);
    act_valid = 1'b1;
    act_addr = 32'h0000_0000;
    @(negedge i_clock);
    act_valid = 1'b0;
    repeat (4) @(negedge i_clock);
    i_rst_n = 1'b0;
    @(negedge i_clock);
    check("busy after reset", {31'h0, busy}, 32'h0);
    check("req after reset", {31'h0, mem_req}, 32'h0);
    i_rst_n = 1'b1;
    activate(32'h0000_0000);
    check("rst src", rd32(4), 32'h0000_0104);
    check("rst cnt", rd32(12) >> 16, 32'h0002);
    check("rst irq", irq_cnt - irq0, 32'h0);
    check("rst flag", flag_cnt - flag0, 32'h1);
    $display("test mid reset done");
    close_out();
  end
endmodule : transfer_descriptor_counters_tb
